// >>> hw/cfgfe_clkdiv.sv
// Programmable divider making the memory-programming clock enable.
// Assumes lf_tick is a one-cycle pulse per low-frequency clock period.
`timescale 1ns/1ps
module cfgfe_clkdiv
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic lf_tick,
   input wire logic [5:0] div_code,
   output logic prog_tick
);

   // ----------------------------------------------------------------
   // Divide by one for code 0, else by twice the code
   // ----------------------------------------------------------------
   logic [6:0] cnt_reg;
   logic [6:0] cnt_next;
   logic [6:0] div_last;
   logic wrap;
   logic tick_reg;

   // Terminal count; code 63 gives 126 periods
   assign div_last = (div_code == 6'h00) ? 7'h00 :
                     7'({div_code, 1'b0} - 7'h01);
   assign wrap = lf_tick && (cnt_reg >= div_last);
   assign cnt_next = wrap ? 7'h00 : 7'(cnt_reg + 7'h01);

   // Counter advances on the low-frequency tick only
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 7'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         if (lf_tick)
            cnt_reg <= cnt_next;
         tick_reg <= wrap;
      end
   end

   assign prog_tick = tick_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_div_one;
      @(posedge sys_clk) disable iff (!rst_n)
      (lf_tick && div_code == 6'h00) |=> prog_tick;
   endproperty
   a_div_one: assert property (p_div_one)
      else $error("divide by one lost a tick");

   property p_no_tick_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      !lf_tick |=> !prog_tick;
   endproperty
   a_no_tick_idle: assert property (p_no_tick_idle)
      else $error("program tick without low-frequency tick");

endmodule

// >>> hw/cfgfe_pkg.sv
// Package for the clock and front-end configuration register bank.
// Assumes an AXI4-Lite slave with 32-bit data, one register per word.
package cfgfe_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_OSC_CTRL = 4'h4;
   localparam logic [3:0] IDX_PROG_DIV = 4'h5;
   localparam logic [3:0] IDX_FAST_SEL = 4'h6;
   localparam logic [3:0] IDX_TRIG_CFG = 4'h7;
   localparam logic [3:0] IDX_DCHG_CFG = 4'h8;
   localparam logic [3:0] IDX_CHG_CFG = 4'h9;
   localparam logic [3:0] IDX_STATUS = 4'ha;
   localparam int NUM_REGS = 16;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int OSC_DIS_BIT = 7;
   localparam int OSC_GAIN_BIT = 6;
   localparam int OSC_DIV4_BIT = 5;
   localparam int OSC_RUN_LSB = 0;
   localparam int TRIG_DUMMY_DIS_BIT = 4;
   localparam int TRIG_SYM_EN_BIT = 3;
   localparam int TRIG_INVERT_BIT = 2;
   localparam int TRIG_SEL_LSB = 0;
   localparam int DCHG_UPPER_LSB = 6;
   localparam int DCHG_LOWER_LSB = 4;
   localparam int DCHG_INT_EN_BIT = 3;
   localparam int DCHG_EXT_EN_BIT = 1;
   localparam int DCHG_MEG_BIT = 0;
   localparam int AUX_ACT_BIT = 6;
   localparam int AUX_CAP_BIT = 5;
   localparam int EARLY_OPEN_BIT = 4;
   localparam int PERM_CONN_BIT = 3;
   localparam int EXT_PERM_BIT = 2;
   localparam int CHG_SEL_LSB = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_OSC_CTRL = 8'h80;
   localparam logic [7:0] RST_PROG_DIV = 8'h00;
   localparam logic [7:0] RST_FAST_SEL = 8'h01;
   localparam logic [7:0] RST_TRIG_CFG = 8'h00;
   localparam logic [7:0] RST_DCHG_CFG = 8'h00;
   localparam logic [7:0] RST_CHG_CFG = 8'h00;

   // ----------------------------------------------------------------
   // Encodings and timing
   // ----------------------------------------------------------------
   localparam logic [2:0] RUN_OFF = 3'h0;
   localparam logic [2:0] RUN_PERM = 3'h1;
   localparam logic [2:0] RUN_LAT31 = 3'h2;
   localparam logic [2:0] RUN_LAT2 = 3'h3;
   localparam logic [2:0] RUN_LAT1 = 3'h6;
   localparam logic [4:0] LAT_31 = 5'h1f;
   localparam logic [4:0] LAT_2 = 5'h02;
   localparam logic [4:0] LAT_1 = 5'h01;
   localparam logic [2:0] FAST_INT1 = 3'h1;
   localparam logic [2:0] FAST_INT2 = 3'h2;
   localparam logic [2:0] FAST_EXT = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WARM_IDLE,
      WARM_WAIT,
      WARM_READY
   } cfgfe_warm_t;

endpackage

// >>> hw/cfgfe_top.sv
// Clock and front-end configuration register bank with oscillator
// warm-up sequencer and memory-programming clock divider.
// Assumes an AXI4-Lite master on sys_clk and a low-frequency clock
// arriving as a pin that is sampled here.
//
// Function
// - Oscillator disable bit 1 turns the pad clock generator off.
// - Gain trim bit selects low (0) or high (1) oscillator gain.
// - Divide bit 1 makes the oscillator clock the raw rate over 4.
// - Run field: 0 off, 1 permanent, 2/3/6 pulsed, latency 31/2/1.
// - In pulsed mode start the oscillator and wait the latency.
// - Program clock divides low clock by 1 (code 0) to 126 (63).
// - Fast clock select: 1 internal one, 2 internal two, 4 external.
// - Dummy discharge disable 0 runs dummy cycles, 1 does not.
// - Sense invert bit inverts the trigger level to the converter.
// - Upper port discharge resistor: 180k, 90k, 30k, 10k ohm.
// - Lower and special port discharge resistor selected alike.
// - Megohm bit replaces lower and special kilo-ohm paths only.
// - Auxiliary activate bit 1 disables the port pull-downs.
// - Early open bit 1 disconnects the discharge resistor early.
// - Charge resistor select: 180k, 90k, 30k, 10k ohm.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module cfgfe_top
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic low_frequency_clock,
   input wire logic measure_request,
   input wire logic trigger_level,
   output logic measure_start,
   output logic pad_oscillator_enable,
   output logic pad_oscillator_gain_trim,
   output logic pad_oscillator_quarter_divide,
   output logic pad_oscillator_internal_a,
   output logic pad_oscillator_internal_b,
   output logic program_clock_tick,
   output logic [2:0] fast_clock_source_select,
   output logic dummy_discharge_enable,
   output logic trigger_dummy_symmetry_enable,
   output logic [1:0] trigger_select,
   output logic converter_level,
   output logic [1:0] upper_port_discharge_resistor,
   output logic [1:0] lower_port_discharge_resistor,
   output logic lower_port_megohm_select,
   output logic internal_discharge_enable,
   output logic external_discharge_enable,
   output logic auxiliary_pulldown_enable,
   output logic auxiliary_internal_cap,
   output logic discharge_early_open,
   output logic discharge_permanent_connect,
   output logic external_discharge_permanent,
   output logic [1:0] charge_resistor_select
);

   // ----------------------------------------------------------------
   // Register index decode, shared by both bus channels
   // ----------------------------------------------------------------
   function automatic logic [3:0] reg_index(input logic [5:0] addr);
      reg_index = addr[5:2];
   endfunction

   function automatic logic idx_mapped(input logic [3:0] idx);
      idx_mapped = (idx >= cfgfe_pkg::IDX_OSC_CTRL) &&
                   (idx <= cfgfe_pkg::IDX_STATUS);
   endfunction

   logic [7:0] osc_reg;
   logic [7:0] div_reg;
   logic [7:0] fast_reg;
   logic [7:0] trig_reg;
   logic [7:0] dchg_reg;
   logic [7:0] chg_reg;

   // ----------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ----------------------------------------------------------------
   logic aw_held_reg;
   logic w_held_reg;
   logic [3:0] aw_idx_reg;
   logic [7:0] w_data_reg;
   logic w_lane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic [3:0] wr_idx;
   logic [7:0] wr_data;
   logic wr_lane;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_fire = (aw_held_reg || aw_take) && (w_held_reg || w_take);
   assign wr_idx = aw_held_reg ? aw_idx_reg : reg_index(s_axi_awaddr);
   assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata[7:0];
   assign wr_lane = w_held_reg ? w_lane_reg : s_axi_wstrb[0];

   // Hold whichever half arrives first until the other comes
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_idx_reg <= 4'h0;
         w_data_reg <= 8'h00;
         w_lane_reg <= 1'b0;
      end
      else
      begin
         aw_held_reg <= (aw_held_reg || aw_take) && !wr_fire;
         w_held_reg <= (w_held_reg || w_take) && !wr_fire;
         if (aw_take)
            aw_idx_reg <= reg_index(s_axi_awaddr);
         if (w_take)
         begin
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
         end
      end
   end

   // Response; unmapped or read-only targets answer with an error
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= cfgfe_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (idx_mapped(wr_idx) &&
                       wr_idx != cfgfe_pkg::IDX_STATUS) ?
                      cfgfe_pkg::RESP_OKAY : cfgfe_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // ----------------------------------------------------------------
   // Configuration registers; only byte lane 0 carries data
   // ----------------------------------------------------------------
   logic wr_en;
   assign wr_en = wr_fire && wr_lane;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_reg <= cfgfe_pkg::RST_OSC_CTRL;
         div_reg <= cfgfe_pkg::RST_PROG_DIV;
         fast_reg <= cfgfe_pkg::RST_FAST_SEL;
         trig_reg <= cfgfe_pkg::RST_TRIG_CFG;
         dchg_reg <= cfgfe_pkg::RST_DCHG_CFG;
         chg_reg <= cfgfe_pkg::RST_CHG_CFG;
      end
      else if (wr_en)
      begin
         case (wr_idx)
            cfgfe_pkg::IDX_OSC_CTRL: osc_reg <= wr_data;
            cfgfe_pkg::IDX_PROG_DIV: div_reg <= {2'b00, wr_data[5:0]};
            cfgfe_pkg::IDX_FAST_SEL: fast_reg <= {5'h00, wr_data[2:0]};
            cfgfe_pkg::IDX_TRIG_CFG: trig_reg <= {3'h0, wr_data[4:0]};
            cfgfe_pkg::IDX_DCHG_CFG: dchg_reg <= wr_data;
            cfgfe_pkg::IDX_CHG_CFG: chg_reg <= {1'b0, wr_data[6:0]};
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Low-frequency clock pin: three stages, edge once two agree
   // ----------------------------------------------------------------
   logic [2:0] lf_sync_reg;
   logic lf_level_reg;
   logic lf_tick;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lf_sync_reg <= 3'h0;
         lf_level_reg <= 1'b0;
      end
      else
      begin
         lf_sync_reg <= {lf_sync_reg[1:0], low_frequency_clock};
         if (lf_sync_reg[1] == lf_sync_reg[2])
            lf_level_reg <= lf_sync_reg[2];
      end
   end

   // One pulse per rising low-frequency edge
   assign lf_tick = (lf_sync_reg[1] == lf_sync_reg[2]) &&
                    lf_sync_reg[2] && !lf_level_reg;

   // ----------------------------------------------------------------
   // Oscillator run mode and pulsed warm-up sequencer
   // ----------------------------------------------------------------
   logic [2:0] run_mode;
   logic run_perm;
   logic run_pulsed;
   logic [4:0] latency;
   cfgfe_pkg::cfgfe_warm_t warm_reg;
   cfgfe_pkg::cfgfe_warm_t warm_next;
   logic [4:0] warm_cnt_reg;
   logic start_reg;

   assign run_mode = osc_reg[cfgfe_pkg::OSC_RUN_LSB +: 3];
   assign run_perm = (run_mode == cfgfe_pkg::RUN_PERM);
   // Undefined run codes are treated as off
   assign run_pulsed = (run_mode == cfgfe_pkg::RUN_LAT31) ||
                       (run_mode == cfgfe_pkg::RUN_LAT2) ||
                       (run_mode == cfgfe_pkg::RUN_LAT1);
   assign latency = (run_mode == cfgfe_pkg::RUN_LAT31) ? cfgfe_pkg::LAT_31 :
                    (run_mode == cfgfe_pkg::RUN_LAT2) ? cfgfe_pkg::LAT_2 :
                    cfgfe_pkg::LAT_1;

   // Permanent mode starts at once; pulsed waits out the warm-up
   always_comb
   begin
      warm_next = warm_reg;
      case (warm_reg)
         cfgfe_pkg::WARM_IDLE:
            if (measure_request && run_pulsed)
               warm_next = cfgfe_pkg::WARM_WAIT;
         cfgfe_pkg::WARM_WAIT:
            if (!run_pulsed)
               warm_next = cfgfe_pkg::WARM_IDLE;
            else if (lf_tick && warm_cnt_reg == 5'h01)
               warm_next = cfgfe_pkg::WARM_READY;
         cfgfe_pkg::WARM_READY:
            warm_next = cfgfe_pkg::WARM_IDLE;
         default:
            warm_next = cfgfe_pkg::WARM_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         warm_reg <= cfgfe_pkg::WARM_IDLE;
         warm_cnt_reg <= 5'h00;
         start_reg <= 1'b0;
      end
      else
      begin
         warm_reg <= warm_next;
         if (warm_reg == cfgfe_pkg::WARM_IDLE)
            warm_cnt_reg <= latency;
         else if (lf_tick && warm_cnt_reg != 5'h00)
            warm_cnt_reg <= warm_cnt_reg - 5'h01;
         start_reg <= (warm_next == cfgfe_pkg::WARM_READY) ||
                      (warm_reg == cfgfe_pkg::WARM_IDLE &&
                       measure_request && run_perm);
      end
   end

   assign measure_start = start_reg;

   // ----------------------------------------------------------------
   // Memory-programming clock divider; rate set by software
   // ----------------------------------------------------------------
   cfgfe_clkdiv u_div
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .lf_tick(lf_tick),
      .div_code(div_reg[5:0]),
      .prog_tick(program_clock_tick)
   );

   // ----------------------------------------------------------------
   // Front-end controls, registered for glitch-free analog inputs
   // ----------------------------------------------------------------
   logic osc_on_reg;
   logic level_reg;
   logic osc_on_next;

   // Disable bit overrides; pulsed mode only runs while the sequencer is in WARM_WAIT or WARM_READY
   assign osc_on_next = !osc_reg[cfgfe_pkg::OSC_DIS_BIT] &&
                        (run_perm || (run_pulsed &&
                         warm_reg != cfgfe_pkg::WARM_IDLE));

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_on_reg <= 1'b0;
         level_reg <= 1'b0;
      end
      else
      begin
         osc_on_reg <= osc_on_next;
         level_reg <= trigger_level ^
                      trig_reg[cfgfe_pkg::TRIG_INVERT_BIT];
      end
   end

   assign pad_oscillator_enable = osc_on_reg;
   assign pad_oscillator_gain_trim = osc_reg[cfgfe_pkg::OSC_GAIN_BIT];
   assign pad_oscillator_quarter_divide =
      osc_reg[cfgfe_pkg::OSC_DIV4_BIT];
   assign pad_oscillator_internal_a = osc_reg[4];
   assign pad_oscillator_internal_b = osc_reg[3];
   assign fast_clock_source_select = fast_reg[2:0];
   assign dummy_discharge_enable =
      !trig_reg[cfgfe_pkg::TRIG_DUMMY_DIS_BIT];
   assign trigger_dummy_symmetry_enable =
      trig_reg[cfgfe_pkg::TRIG_SYM_EN_BIT];
   assign trigger_select = trig_reg[cfgfe_pkg::TRIG_SEL_LSB +: 2];
   assign converter_level = level_reg;
   assign upper_port_discharge_resistor =
      dchg_reg[cfgfe_pkg::DCHG_UPPER_LSB +: 2];
   assign lower_port_discharge_resistor =
      dchg_reg[cfgfe_pkg::DCHG_LOWER_LSB +: 2];
   assign lower_port_megohm_select =
      dchg_reg[cfgfe_pkg::DCHG_MEG_BIT];
   assign internal_discharge_enable = dchg_reg[cfgfe_pkg::DCHG_INT_EN_BIT];
   assign external_discharge_enable = dchg_reg[cfgfe_pkg::DCHG_EXT_EN_BIT];
   assign auxiliary_pulldown_enable =
      !chg_reg[cfgfe_pkg::AUX_ACT_BIT];
   assign auxiliary_internal_cap = chg_reg[cfgfe_pkg::AUX_CAP_BIT];
   assign discharge_early_open = chg_reg[cfgfe_pkg::EARLY_OPEN_BIT];
   assign discharge_permanent_connect = chg_reg[cfgfe_pkg::PERM_CONN_BIT];
   assign external_discharge_permanent = chg_reg[cfgfe_pkg::EXT_PERM_BIT];
   assign charge_resistor_select =
      chg_reg[cfgfe_pkg::CHG_SEL_LSB +: 2];

   // ----------------------------------------------------------------
   // Read channel: one read at a time, data from a flip-flop
   // ----------------------------------------------------------------
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [3:0] rd_idx;
   logic [7:0] rd_mux;
   logic [7:0] status_word;

   // Status shows the live sequencer and oscillator state
   assign status_word = {5'h00, osc_on_reg, warm_reg};
   assign s_axi_arready = !rvalid_reg;
   assign rd_idx = reg_index(s_axi_araddr);
   assign rd_mux = (rd_idx == cfgfe_pkg::IDX_OSC_CTRL) ? osc_reg :
                   (rd_idx == cfgfe_pkg::IDX_PROG_DIV) ? div_reg :
                   (rd_idx == cfgfe_pkg::IDX_FAST_SEL) ? fast_reg :
                   (rd_idx == cfgfe_pkg::IDX_TRIG_CFG) ? trig_reg :
                   (rd_idx == cfgfe_pkg::IDX_DCHG_CFG) ? dchg_reg :
                   (rd_idx == cfgfe_pkg::IDX_CHG_CFG) ? chg_reg :
                   (rd_idx == cfgfe_pkg::IDX_STATUS) ? status_word : 8'h00;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= cfgfe_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_mux};
         rresp_reg <= idx_mapped(rd_idx) ? cfgfe_pkg::RESP_OKAY :
                      cfgfe_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_osc_disable;
      @(posedge sys_clk) disable iff (!rst_n)
      osc_reg[cfgfe_pkg::OSC_DIS_BIT] |=> !pad_oscillator_enable;
   endproperty
   a_osc_disable: assert property (p_osc_disable)
      else $error("oscillator on while disabled");

   property p_osc_off_mode;
      @(posedge sys_clk) disable iff (!rst_n)
      (run_mode == cfgfe_pkg::RUN_OFF) |=> !pad_oscillator_enable;
   endproperty
   a_osc_off_mode: assert property (p_osc_off_mode)
      else $error("oscillator on in off mode");

   property p_perm_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (warm_reg == cfgfe_pkg::WARM_IDLE && measure_request && run_perm)
      |=> measure_start;
   endproperty
   a_perm_start: assert property (p_perm_start)
      else $error("permanent mode start delayed");

   property p_warm_before_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (measure_start && run_pulsed) |-> $past(warm_reg) ==
         cfgfe_pkg::WARM_WAIT;
   endproperty
   a_warm_before_start: assert property (p_warm_before_start)
      else $error("pulsed start without warm-up");

   property p_invert;
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 converter_level == ($past(trigger_level) ^
                             $past(trig_reg[cfgfe_pkg::TRIG_INVERT_BIT]));
   endproperty
   a_invert: assert property (p_invert)
      else $error("converter level polarity wrong");

   property p_write_lands;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_en && wr_idx == cfgfe_pkg::IDX_CHG_CFG) |=>
      auxiliary_pulldown_enable == !$past(wr_data[cfgfe_pkg::AUX_ACT_BIT]);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("auxiliary activate write lost");

endmodule

// >>> sim/cfgfe_tb.sv
// Testbench for the clock and front-end configuration bank.
// Drives AXI4-Lite and all pins itself; low-frequency pin runs free.
`timescale 1ns/1ps
module clock_and_frontend_config_tb_top;
   logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
      s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
      s_axi_rvalid, s_axi_rready, measure_request, trigger_level,
      measure_start, pad_oscillator_enable, pad_oscillator_gain_trim,
      pad_oscillator_quarter_divide, pad_oscillator_internal_a,
      pad_oscillator_internal_b, program_clock_tick, dummy_discharge_enable,
      trigger_dummy_symmetry_enable, converter_level, lower_port_megohm_select,
      internal_discharge_enable, external_discharge_enable,
      auxiliary_pulldown_enable, auxiliary_internal_cap, discharge_early_open,
      discharge_permanent_connect, external_discharge_permanent;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, trigger_select,
      charge_resistor_select, upper_port_discharge_resistor,
      lower_port_discharge_resistor;
   logic [2:0] fast_clock_source_select;
   logic [2:0] lf_cnt = 3'h0;
   logic low_frequency_clock = 1'b0;
   int fails = 0;
   int checked = 0;
   int n;
   cfgfe_top uut (.*);
   // ------------------------------------------------------------
   // Clocks: low-frequency period is 8 system cycles
   // ------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      lf_cnt <= lf_cnt + 3'h1;
      low_frequency_clock <= lf_cnt[2];
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task test_done;
   begin
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
   begin
      checked++;
      if (s !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, s);
         fails++;
      end
   end
   endtask
   // Bus tasks hold each channel until its own ready edge
   task wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
   begin
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 20 && !s_axi_bvalid; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (n == 20) begin fails++; test_done; end
      chk("bresp", er, s_axi_bresp);
      // Registered outputs follow the register one edge later
      @(posedge sys_clk);
   end
   endtask
   task rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
   begin
      @(posedge sys_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 20 && !s_axi_rvalid; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (n == 20) begin fails++; test_done; end
      chk("rdata", {24'h0, e}, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_osc;
   begin
      rd(6'h10, 8'h80, 2'h0);
      chk("osc_en", 0, pad_oscillator_enable);
      wr(6'h10, 8'h71, 2'h0);
      chk("gain", 1, pad_oscillator_gain_trim);
      chk("div4", 1, pad_oscillator_quarter_divide);
      chk("osc_en", 1, pad_oscillator_enable);
      chk("osc_int", 2, {pad_oscillator_internal_a,
         pad_oscillator_internal_b});
      rd(6'h28, 8'h04, 2'h0);
      wr(6'h10, 8'he1, 2'h0);
      chk("osc_en", 0, pad_oscillator_enable);
      wr(6'h10, 8'h00, 2'h0);
      chk("osc_en", 0, pad_oscillator_enable);
      rd(6'h3c, 8'h00, 2'h2);
      wr(6'h28, 8'h07, 2'h2);
   end
   endtask
   // Request, then count cycles to the start pulse per run code
   task t_meas;
      logic [2:0] code [4] = '{3'h1, 3'h3, 3'h6, 3'h2};
      // N periods of 8 cycles, pin phase unknown: 8N-6 to 8N+1
      int lo [4] = '{1, 10, 2, 242};
      int hi [4] = '{1, 17, 9, 249};
   begin
      for (int i = 0; i < 4; i++)
      begin
         wr(6'h10, {5'h0, code[i]}, 2'h0);
         measure_request <= 1'b1;
         @(posedge sys_clk);
         measure_request <= 1'b0;
         for (n = 0; n < 300 && !measure_start; n++)
         begin
            @(posedge sys_clk);
            if (n == 2 && i > 0)
               chk("warm_osc", 1, pad_oscillator_enable);
         end
         chk("lat_ok", 1, n >= lo[i] && n <= hi[i]);
         @(posedge sys_clk);
         chk("start_pulse", 0, measure_start);
      end
   end
   endtask
   task t_div;
      logic [7:0] code [3] = '{8'h00, 8'h02, 8'h3f};
      int per [3] = '{8, 32, 1008};
   begin
      for (int i = 0; i < 3; i++)
      begin
         wr(6'h14, code[i], 2'h0);
         for (int k = 0; k < 3; k++)
         begin
            @(posedge sys_clk);
            for (n = 1; n < 1100 && !program_clock_tick; n++)
               @(posedge sys_clk);
         end
         chk("prog_period", per[i], n);
      end
   end
   endtask
   task t_fields;
   begin
      wr(6'h20, 8'hd9, 2'h0);
      chk("upper_r", 3, upper_port_discharge_resistor);
      chk("lower_r", 1, lower_port_discharge_resistor);
      chk("megohm", 1, lower_port_megohm_select);
      chk("dchg_en", 2, {internal_discharge_enable,
         external_discharge_enable});
      wr(6'h24, 8'h5a, 2'h0);
      chk("aux_pd", 0, auxiliary_pulldown_enable);
      chk("early", 1, discharge_early_open);
      chk("chg_r", 2, charge_resistor_select);
      chk("chg_misc", 2, {auxiliary_internal_cap,
         discharge_permanent_connect, external_discharge_permanent});
      wr(6'h1c, 8'h14, 2'h0);
      trigger_level <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("dummy_en", 0, dummy_discharge_enable);
      chk("conv_lvl", 0, converter_level);
      wr(6'h1c, 8'h0b, 2'h0);
      chk("conv_lvl", 1, converter_level);
      chk("dummy_en", 1, dummy_discharge_enable);
      chk("trig_misc", 7, {trigger_dummy_symmetry_enable,
         trigger_select});
      for (int i = 0; i < 3; i++)
      begin
         wr(6'h18, 8'h01 << i, 2'h0);
         chk("fast_sel", 1 << i, fast_clock_source_select);
      end
   end
   endtask
   initial
   begin
      rst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_rready, measure_request, trigger_level} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
      s_axi_wstrb = 4'hf;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_osc;
      t_meas;
      t_div;
      t_fields;
      test_done;
   end
endmodule
